// *** design/irq_pend_params.svh ***
// Offsets, bit layouts and reset values of the set-pending register block.
`ifndef IRQ_PEND_PARAMS_SVH
`define IRQ_PEND_PARAMS_SVH

`define IRQ_COUNT 50
`define APB_ADDR_W 12
`define APB_DATA_W 32
`define LOW_WORD_W 32
`define HIGH_WORD_W 18

`define OFF_FORCE_LO 12'h000
`define OFF_FORCE_HI 12'h004
`define OFF_REMOVE_LO 12'h008
`define OFF_REMOVE_HI 12'h00C
`define OFF_ENABLE_LO 12'h010
`define OFF_ENABLE_HI 12'h014
`define OFF_DISABLE_LO 12'h018
`define OFF_DISABLE_HI 12'h01C

// Interrupts 12-14 and 39 do not exist.
`define IRQ_IMPL_MASK 50'h3FF7FFFFF8FFF
`define IRQ_RESET_VALUE 50'h0000000000000
`define RDATA_RESET_VALUE 32'h00000000
`define HIGH_PAD_ZERO 14'h0000

`endif

// *** design/irq_pend_pkg.sv ***
// Types shared by the set-pending register block.
package irq_pend_pkg;
`include "irq_pend_params.svh"

   typedef logic [`IRQ_COUNT-1:0] irq_vec_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`APB_ADDR_W-1:0] paddr;
      logic [`APB_DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef enum {
      SEL_NONE,
      SEL_FORCE_LO,
      SEL_FORCE_HI,
      SEL_REMOVE_LO,
      SEL_REMOVE_HI,
      SEL_ENABLE_LO,
      SEL_ENABLE_HI,
      SEL_DISABLE_LO,
      SEL_DISABLE_HI
   } reg_sel_t;
endpackage

// *** design/pend_bit_bank.sv ***
// A bank of flags, each set and cleared by its own strobe; a set beats a clear.
`timescale 1ns/1ps
module pend_bit_bank #(
   parameter int WIDTH = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clr_bits,
   output logic [WIDTH-1:0] state
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= (state & ~clr_bits) | set_bits;
      end
   end
endmodule

// *** design/interrupt_set_pending_regs.sv ***
// APB register block for forcing, clearing and reading interrupt pending state.
`timescale 1ns/1ps
`include "irq_pend_params.svh"

// What this block does
// - Writing 1 pends the mapped interrupt.
// - No change if already pending or disabled.
// - Writing 0 leaves pending state alone.
// - Reads of the force and remove words return live pending status per bit; enable and disable words return enable status.
// - Clear-pending write of 1 removes pending.
// - Interrupt number equals bit position, gaps unimplemented.
// - Clear-enable write of 1 disables interrupt.
module interrupt_set_pending_regs
   import irq_pend_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic [`APB_DATA_W-1:0] pwdata,
   output logic [`APB_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`IRQ_COUNT-1:0] irq_request,
   output logic [`IRQ_COUNT-1:0] pending,
   output logic [`IRQ_COUNT-1:0] enabled
);

   apb_req_t req;
   reg_sel_t sel;
   irq_vec_t wvec;
   irq_vec_t enabled_state;
   irq_vec_t pending_state;
   irq_vec_t pend_set;
   irq_vec_t pend_clr;
   irq_vec_t ena_set;
   irq_vec_t ena_clr;
   logic setup_phase;
   logic access_wr;
   logic wr_force;
   logic wr_remove;
   logic wr_enable;
   logic wr_disable;

   function automatic reg_sel_t decode(input logic [`APB_ADDR_W-1:0] addr);
      case (addr)
         `OFF_FORCE_LO: decode = SEL_FORCE_LO;
         `OFF_FORCE_HI: decode = SEL_FORCE_HI;
         `OFF_REMOVE_LO: decode = SEL_REMOVE_LO;
         `OFF_REMOVE_HI: decode = SEL_REMOVE_HI;
         `OFF_ENABLE_LO: decode = SEL_ENABLE_LO;
         `OFF_ENABLE_HI: decode = SEL_ENABLE_HI;
         `OFF_DISABLE_LO: decode = SEL_DISABLE_LO;
         `OFF_DISABLE_HI: decode = SEL_DISABLE_HI;
         default: decode = SEL_NONE;
      endcase
   endfunction

   function automatic logic is_high(input reg_sel_t s);
      is_high = (s == SEL_FORCE_HI) || (s == SEL_REMOVE_HI) ||
                (s == SEL_ENABLE_HI) || (s == SEL_DISABLE_HI);
   endfunction

   // The low word holds interrupts 0-31; the high word starts at interrupt 32.
   function automatic irq_vec_t place_word(input logic high,
                                           input logic [`APB_DATA_W-1:0] data);
      irq_vec_t v;
      v = '0;
      if (high) begin
         v[`IRQ_COUNT-1:`LOW_WORD_W] = data[`HIGH_WORD_W-1:0];
      end else begin
         v[`LOW_WORD_W-1:0] = data;
      end
      place_word = v & `IRQ_IMPL_MASK;
   endfunction

   function automatic logic [`APB_DATA_W-1:0] pick_word(input logic high, input irq_vec_t v);
      irq_vec_t m;
      m = v & `IRQ_IMPL_MASK;
      if (high) begin
         pick_word = {`HIGH_PAD_ZERO, m[`IRQ_COUNT-1:`LOW_WORD_W]};
      end else begin
         pick_word = m[`LOW_WORD_W-1:0];
      end
   endfunction

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};
   assign sel = decode(req.paddr);
   assign setup_phase = req.psel && !req.penable;
   assign access_wr = req.psel && req.penable && req.pwrite;

   // bit mapping
   // Masking here keeps the missing interrupts from ever holding state.
   assign wvec = place_word(is_high(sel), req.pwdata);

   assign wr_force = access_wr && ((sel == SEL_FORCE_LO) || (sel == SEL_FORCE_HI));
   assign wr_remove = access_wr && ((sel == SEL_REMOVE_LO) || (sel == SEL_REMOVE_HI));
   assign wr_enable = access_wr && ((sel == SEL_ENABLE_LO) || (sel == SEL_ENABLE_HI));
   assign wr_disable = access_wr && ((sel == SEL_DISABLE_LO) || (sel == SEL_DISABLE_HI));

   // zeros ignored
   // A source request arriving with a clear in the same cycle still lands.
   assign pend_set = ((wr_force ? wvec : '0) | irq_request) & enabled_state & `IRQ_IMPL_MASK;

   assign pend_clr = wr_remove ? wvec : '0;

   assign ena_set = wr_enable ? wvec : '0;

   assign ena_clr = wr_disable ? wvec : '0;

   pend_bit_bank #(
      .WIDTH(`IRQ_COUNT)
   ) pending_bank (
      .pclk(pclk),
      .presetn(presetn),
      .set_bits(pend_set),
      .clr_bits(pend_clr),
      .state(pending_state)
   );

   pend_bit_bank #(
      .WIDTH(`IRQ_COUNT)
   ) enable_bank (
      .pclk(pclk),
      .presetn(presetn),
      .set_bits(ena_set),
      .clr_bits(ena_clr),
      .state(enabled_state)
   );

   assign pending = pending_state;
   assign enabled = enabled_state;

   // high bits zero
   // Read data is captured in the setup cycle, so it shows the state as it
   // stood at that edge; that early snapshot is the price of a flopped prdata with zero wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `RDATA_RESET_VALUE;
      end else if (setup_phase && !req.pwrite) begin
         case (sel)
            SEL_FORCE_LO, SEL_FORCE_HI, SEL_REMOVE_LO, SEL_REMOVE_HI: begin
               prdata <= pick_word(is_high(sel), pending_state);
            end
            SEL_ENABLE_LO, SEL_ENABLE_HI, SEL_DISABLE_LO, SEL_DISABLE_HI: begin
               prdata <= pick_word(is_high(sel), enabled_state);
            end
            default: begin
               prdata <= `RDATA_RESET_VALUE;
            end
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = req.psel && req.penable && (sel == SEL_NONE);

   a_force_sets_pend: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_force |=> ((pending & $past(wvec) & $past(enabled)) == ($past(wvec) & $past(enabled))))
      else $error("Enabled interrupt not pended by a force write.");

   a_disabled_no_pend: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((pending & ~$past(pending) & ~$past(enabled)) == '0))
      else $error("Disabled interrupt became pending.");

   a_zero_no_effect: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_force |=> (((pending ^ $past(pending)) & ~$past(wvec) & ~$past(irq_request)) == '0))
      else $error("Force write changed a bit that was written 0.");

   a_read_live_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && paddr == `OFF_FORCE_LO)
      |=> (prdata == `APB_DATA_W'($past(pending) & `IRQ_IMPL_MASK)))
      else $error("Low pending readback differs from pending state.");

   a_remove_clears: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_remove && ((irq_request & wvec) == '0)) |=> ((pending & $past(wvec)) == '0))
      else $error("Clear-pending write left a bit pending.");

   a_map_unimpl: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((pending | enabled) & ~`IRQ_IMPL_MASK) == '0)
      else $error("Unimplemented interrupt holds state.");

   a_disable_clears: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_disable |=> ((enabled & $past(wvec)) == '0))
      else $error("Clear-enable write left an interrupt enabled.");

   a_high_reads_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_phase && !pwrite && paddr == `OFF_FORCE_HI)
      |=> (prdata[`APB_DATA_W-1:`HIGH_WORD_W] == '0 &&
           prdata[`HIGH_WORD_W-1:0] == $past(pending[`IRQ_COUNT-1:`LOW_WORD_W])))
      else $error("High pending readback wrong or upper bits nonzero.");

   a_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> (pslverr == (decode(paddr) == SEL_NONE)))
      else $error("Error response does not match address decode.");

   a_request_pends: assert property (
      @(posedge pclk) disable iff (!presetn)
      (|irq_request) |=> ((pending & $past(irq_request) & $past(enabled)) ==
                          ($past(irq_request) & $past(enabled))))
      else $error("Enabled source request did not pend its interrupt.");

   a_refused_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access_wr && sel == SEL_NONE)
      |=> (enabled == $past(enabled) &&
           ((pending ^ $past(pending)) & ~$past(irq_request)) == '0))
      else $error("Write to an unmapped address changed state.");

endmodule

// *** testbench/irq_source_model.sv ***
// Interrupt sources that raise one-cycle pend requests on command.
`timescale 1ns/1ps
module irq_source_model
   import irq_pend_pkg::*;
(
   input wire logic pclk,
   output irq_vec_t irq_request
);
   initial irq_request = '0;
   // Requests last one cycle, so a disabled one that is dropped cannot reappear later.
   task raise(input irq_vec_t v);
      irq_request <= v;
      @(posedge pclk);
      irq_request <= '0;
   endtask
endmodule

// *** testbench/testbench.sv ***
// Register-level tests of the set-pending block over APB.
`timescale 1ns/1ps
`include "irq_pend_params.svh"
module testbench
   import irq_pend_pkg::*;
;
   localparam irq_vec_t impl = `IRQ_IMPL_MASK;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [`APB_ADDR_W-1:0] paddr;
   logic [`APB_DATA_W-1:0] pwdata, prdata, q;
   logic e;
   irq_vec_t irq_request, pending, enabled;
   int fails = 0;
   int compares = 0;
   interrupt_set_pending_regs interrupt_set_pending_regs_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_request(irq_request),
      .pending(pending), .enabled(enabled));
   irq_source_model irq_source_model_inst (.pclk(pclk), .irq_request(irq_request));
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      chk("read", q, exp);
   endtask
   task tally_and_finish;
      if (fails == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      tally_and_finish;
   end
   initial begin
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rd(`OFF_FORCE_LO, 0);
      // Disabled interrupts ignore a force write.
      apb(1, `OFF_FORCE_LO, impl[31:0]);
      rd(`OFF_FORCE_LO, 0);
      apb(1, `OFF_ENABLE_LO, impl[31:0]);
      apb(1, `OFF_ENABLE_HI, 32'(impl[49:32]));
      chk("enabled", enabled[31:0], impl[31:0]);
      // Lowest and highest of each run of bits, unused bits written 0.
      apb(1, `OFF_FORCE_LO, 32'h80008801);
      rd(`OFF_FORCE_LO, 32'h80008801);
      apb(1, `OFF_FORCE_LO, 32'h00000000);
      rd(`OFF_FORCE_LO, 32'h80008801);
      apb(1, `OFF_FORCE_LO, 32'h00000001);
      rd(`OFF_FORCE_LO, 32'h80008801);
      // Ones in bits 31-18 must be ignored.
      apb(1, `OFF_FORCE_HI, 32'hFFFFFF7F);
      rd(`OFF_FORCE_HI, 32'h0003FF7F);
      chk("pending", pending[31:0], 32'h80008801);
      apb(1, `OFF_REMOVE_LO, 32'h00000001);
      rd(`OFF_FORCE_LO, 32'h80008800);
      apb(1, `OFF_REMOVE_HI, 32'(impl[49:32]));
      rd(`OFF_FORCE_HI, 0);
      apb(1, `OFF_DISABLE_LO, 32'h00008000);
      rd(`OFF_DISABLE_LO, impl[31:0] & 32'hFFFF7FFF);
      apb(1, `OFF_REMOVE_LO, 32'h00008000);
      apb(1, `OFF_FORCE_LO, 32'h00008000);
      rd(`OFF_FORCE_LO, 32'h80000800);
      // Bit 15 is disabled, so its source request is dropped.
      irq_source_model_inst.raise((50'h1 << 40) | (50'h1 << 15));
      rd(`OFF_FORCE_HI, 32'h00000100);
      rd(`OFF_FORCE_LO, 32'h80000800);
      apb(0, 12'h020, 0);
      chk("pslverr", 32'(e), 1);
      chk("unmapped", q, 0);
      chk("pready", 32'(pready), 1);
      apb(1, 12'h020, 32'hFFFFFFFF);
      chk("pslverr_wr", 32'(e), 1);
      chk("pending", pending[31:0], 32'h80000800);
      tally_and_finish;
   end
endmodule
